// ==== verilog/stac_config_regs.v ====
// Configuration register bank of the spectral front end: gain ceilings, FIFO and AGC, thresholds.
//
// Overview of operation
// - Bits 7:4 of the gain ceiling register cap the flicker gain, code 0 is 0.5x doubling to 512x at 10, reset 9.
// - Bits 3:0 of the gain ceiling register cap the spectral gain on the same scale, reset 9.
// - Bits 7:6 of the FIFO config select fill levels 1, 4, 8 or 16 for the first FIFO interrupt, reset code 2.
// - Bit 3 of the FIFO config enables flicker automatic gain control and resets to 1.
// - Bit 2 of the FIFO config enables spectral automatic gain control and resets to 0.
// - Auxiliary, revision and part codes are read-only and writes to them do nothing.
// - The 16-bit low and high thresholds are compared unsigned against each channel zero result.
// - With the interrupt enabled, a persistent out-of-window run sets the spectral interrupt flag.
// - Threshold bytes sit at 0x84, 0x85 and 0x86 and reset to zero.
// - A low-byte write is latched and applied with its high byte in the same cycle.
// - The high byte of the high threshold sits at 0x87, resets to zero and completes it.
// - A status bit clears only when written with one, and writing zero leaves it set.
`include "stac_defs.vh"
module stac_config_regs #(
	parameter [3:0] AUX_CODE = 4'h5,
	parameter [2:0] REV_CODE = 3'h3,
	parameter [5:0] PART_CODE = 6'h2A
)(
	// Clock and reset.
	input wire ref_clk_in,
	input wire rst_in,
	// Register port from the serial interface.
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	output reg [7:0] reg_rdata_out,
	// Measurement input.
	input wire result_valid_in,
	input wire [15:0] channel_zero_result_in,
	// FIFO level from the buffer logic.
	input wire [4:0] fifo_fill_level_in,
	// Configuration to the gain engines.
	output reg [3:0] flicker_gain_ceiling_out,
	output reg [3:0] spectral_gain_ceiling_out,
	output reg flicker_auto_gain_enable_out,
	output reg spectral_auto_gain_enable_out,
	output reg [1:0] fifo_level_threshold_out,
	output reg fifo_threshold_met_out,
	// Thresholds and interrupt.
	output reg [15:0] low_threshold_out,
	output reg [15:0] high_threshold_out,
	output reg spectral_interrupt_flag_out
);
	// The identity defaults above are arbitrary values.
	reg [7:0] lo_latch;
	reg [7:0] hi_latch;
	reg spectral_interrupt_enable;
	reg [`STAC_PERS_W-1:0] interrupt_persistence_count;
	wire hit;

	function wr_at;
		input [7:0] a;
		begin
			wr_at = reg_wr_in && (reg_addr_in == a);
		end
	endfunction

	function [3:0] clamp_ceil;
		input [3:0] c;
		begin
			clamp_ceil = (c > `STAC_CEIL_MAX) ? `STAC_CEIL_MAX : c;
		end
	endfunction

	function [4:0] fifo_level;
		input [1:0] code;
		begin
			case (code)
				2'h0: fifo_level = `STAC_LVL_0;
				2'h1: fifo_level = `STAC_LVL_1;
				2'h2: fifo_level = `STAC_LVL_2;
				default: fifo_level = `STAC_LVL_3;
			endcase
		end
	endfunction

	stac_range_check #(
		.PERS_W(`STAC_PERS_W)
	) u_range (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.low_th_in(low_threshold_out),
		.high_th_in(high_threshold_out),
		.persist_in(interrupt_persistence_count),
		.result_valid_in(result_valid_in),
		.result_in(channel_zero_result_in),
		.hit_out(hit)
	);

	// ********************************************************
	// Register writes.
	// ********************************************************
	always @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			flicker_gain_ceiling_out <= `STAC_CEIL_RST;
			spectral_gain_ceiling_out <= `STAC_CEIL_RST;
			fifo_level_threshold_out <= `STAC_FIFO_LEVEL_THRESHOLD_RST;
			flicker_auto_gain_enable_out <= `STAC_FLK_AGC_RST;
			spectral_auto_gain_enable_out <= `STAC_SPC_AGC_RST;
			lo_latch <= `STAC_BYTE_RST;
			hi_latch <= `STAC_BYTE_RST;
			low_threshold_out <= {`STAC_BYTE_RST, `STAC_BYTE_RST};
			high_threshold_out <= {`STAC_BYTE_RST, `STAC_BYTE_RST};
			spectral_interrupt_enable <= 1'b0;
			interrupt_persistence_count <= {`STAC_PERS_W{1'b0}};
			spectral_interrupt_flag_out <= 1'b0;
			fifo_threshold_met_out <= 1'b0;
		end
		else
		begin
			if (wr_at(`STAC_ADDR_GAIN_CEIL))
			begin
				flicker_gain_ceiling_out <= clamp_ceil(
					reg_wdata_in[`STAC_FLK_CEIL_HI:`STAC_FLK_CEIL_LO]);
				spectral_gain_ceiling_out <= clamp_ceil(
					reg_wdata_in[`STAC_SPC_CEIL_HI:`STAC_SPC_CEIL_LO]);
			end
			if (wr_at(`STAC_ADDR_FIFO_CFG))
			begin
				fifo_level_threshold_out <= reg_wdata_in[`STAC_FIFO_LEVEL_THRESHOLD_HI:`STAC_FIFO_LEVEL_THRESHOLD_LO];
				flicker_auto_gain_enable_out <= reg_wdata_in[`STAC_FLK_AGC_BIT];
				spectral_auto_gain_enable_out <= reg_wdata_in[`STAC_SPC_AGC_BIT];
			end
			fifo_threshold_met_out <= (fifo_fill_level_in >= fifo_level(fifo_level_threshold_out));
			if (wr_at(`STAC_ADDR_TH_LO_L))
			begin
				lo_latch <= reg_wdata_in;
			end
			if (wr_at(`STAC_ADDR_TH_LO_H))
			begin
				low_threshold_out <= {reg_wdata_in, lo_latch};
			end
			if (wr_at(`STAC_ADDR_TH_HI_L))
			begin
				hi_latch <= reg_wdata_in;
			end
			if (wr_at(`STAC_ADDR_TH_HI_H))
			begin
				high_threshold_out <= {reg_wdata_in, hi_latch};
			end
			if (wr_at(`STAC_ADDR_INT_EN))
			begin
				spectral_interrupt_enable <= reg_wdata_in[`STAC_SPC_IEN_BIT];
			end
			if (wr_at(`STAC_ADDR_PERSIST))
			begin
				interrupt_persistence_count <= reg_wdata_in[`STAC_PERS_W-1:0];
			end
			// Set wins over a clear in the same cycle.
			if (hit && spectral_interrupt_enable)
			begin
				spectral_interrupt_flag_out <= 1'b1;
			end
			else if (wr_at(`STAC_ADDR_STATUS) && reg_wdata_in[`STAC_STAT_SPECTRAL_INTERRUPT_FLAG_BIT])
			begin
				spectral_interrupt_flag_out <= 1'b0;
			end
		end
	end

	// ********************************************************
	// Register reads.
	// ********************************************************
	always @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			reg_rdata_out <= `STAC_BYTE_RST;
		end
		else if (reg_rd_in)
		begin
			case (reg_addr_in)
				`STAC_ADDR_TH_LO_L: reg_rdata_out <= lo_latch;
				`STAC_ADDR_TH_LO_H: reg_rdata_out <= low_threshold_out[15:8];
				`STAC_ADDR_TH_HI_L: reg_rdata_out <= hi_latch;
				`STAC_ADDR_TH_HI_H: reg_rdata_out <= high_threshold_out[15:8];
				`STAC_ADDR_AUX_ID: reg_rdata_out <= {4'h0, AUX_CODE};
				`STAC_ADDR_REVISION_CODE: reg_rdata_out <= {5'h00, REV_CODE};
				`STAC_ADDR_PART_ID: reg_rdata_out <= {PART_CODE, 2'h0};
				`STAC_ADDR_STATUS:
					reg_rdata_out <= {4'h0, spectral_interrupt_flag_out, 3'h0};
				`STAC_ADDR_FIFO_CFG:
					reg_rdata_out <= {fifo_level_threshold_out, 2'h0,
						flicker_auto_gain_enable_out, spectral_auto_gain_enable_out, 2'h0};
				`STAC_ADDR_GAIN_CEIL:
					reg_rdata_out <= {flicker_gain_ceiling_out, spectral_gain_ceiling_out};
				`STAC_ADDR_INT_EN: reg_rdata_out <= {4'h0, spectral_interrupt_enable, 3'h0};
				`STAC_ADDR_PERSIST:
					reg_rdata_out <= {{(8-`STAC_PERS_W){1'b0}}, interrupt_persistence_count};
				default: reg_rdata_out <= `STAC_BYTE_RST;
			endcase
		end
	end
endmodule // stac_config_regs

// ==== verilog/stac_defs.vh ====
// Register addresses, field positions, reset values and codes of the configuration bank.
`ifndef STAC_DEFS_VH
`define STAC_DEFS_VH
`define STAC_ADDR_TH_LO_L 8'h84
`define STAC_ADDR_TH_LO_H 8'h85
`define STAC_ADDR_TH_HI_L 8'h86
`define STAC_ADDR_TH_HI_H 8'h87
`define STAC_ADDR_AUX_ID 8'h90
`define STAC_ADDR_REVISION_CODE 8'h91
`define STAC_ADDR_PART_ID 8'h92
`define STAC_ADDR_STATUS 8'h93
`define STAC_ADDR_FIFO_CFG 8'hB1
`define STAC_ADDR_GAIN_CEIL 8'hCF
`define STAC_ADDR_INT_EN 8'hF9
`define STAC_ADDR_PERSIST 8'hBD
`define STAC_FLK_CEIL_HI 7
`define STAC_FLK_CEIL_LO 4
`define STAC_SPC_CEIL_HI 3
`define STAC_SPC_CEIL_LO 0
`define STAC_CEIL_RST 4'h9
`define STAC_CEIL_MAX 4'hA
`define STAC_FIFO_LEVEL_THRESHOLD_HI 7
`define STAC_FIFO_LEVEL_THRESHOLD_LO 6
`define STAC_FIFO_LEVEL_THRESHOLD_RST 2'h2
`define STAC_FLK_AGC_BIT 3
`define STAC_SPC_AGC_BIT 2
`define STAC_FLK_AGC_RST 1'h1
`define STAC_SPC_AGC_RST 1'h0
`define STAC_SPC_IEN_BIT 3
`define STAC_STAT_SPECTRAL_INTERRUPT_FLAG_BIT 3
`define STAC_PERS_W 4
`define STAC_BYTE_RST 8'h00
`define STAC_LVL_0 5'h01
`define STAC_LVL_1 5'h04
`define STAC_LVL_2 5'h08
`define STAC_LVL_3 5'h10
`endif

// ==== verilog/stac_range_check.v ====
// Channel zero window check with consecutive out-of-range persistence counting.
module stac_range_check #(
	parameter PERS_W = 4
)(
	// Clock and reset.
	input wire ref_clk_in,
	input wire rst_in,
	// Thresholds and persistence.
	input wire [15:0] low_th_in,
	input wire [15:0] high_th_in,
	input wire [PERS_W-1:0] persist_in,
	// Result stream.
	input wire result_valid_in,
	input wire [15:0] result_in,
	// Event.
	output reg hit_out
);
	reg [PERS_W:0] run_count;
	wire outside;
	wire [PERS_W:0] run_inc;

	assign outside = (result_in < low_th_in) || (result_in > high_th_in);
	assign run_inc = run_count + {{PERS_W{1'b0}}, 1'b1};

	always @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			run_count <= {(PERS_W+1){1'b0}};
			hit_out <= 1'b0;
		end
		else
		begin
			hit_out <= 1'b0;
			if (result_valid_in)
			begin
				if (!outside)
				begin
					run_count <= {(PERS_W+1){1'b0}};
				end
				else
				begin
					if (run_inc >= {1'b0, persist_in})
					begin
						hit_out <= 1'b1;
					end
					if (run_inc != {(PERS_W+1){1'b1}})
					begin
						run_count <= run_inc;
					end
				end
			end
		end
	end
endmodule // stac_range_check

// ==== sim/stac_config_props.sv ====
// Concurrent checks on the ports of the configuration register bank.
module stac_config_props #(
	parameter logic [5:0] PART_CODE = 6'h2A
)(
	// Clock and reset.
	input logic ref_clk_in,
	input logic rst_in,
	// Register port.
	input logic reg_wr_in,
	input logic reg_rd_in,
	input logic [7:0] reg_addr_in,
	input logic [7:0] reg_wdata_in,
	input logic [7:0] reg_rdata_out,
	// Configuration and events.
	input logic [4:0] fifo_fill_level_in,
	input logic [3:0] flicker_gain_ceiling_out,
	input logic [3:0] spectral_gain_ceiling_out,
	input logic flicker_auto_gain_enable_out,
	input logic spectral_auto_gain_enable_out,
	input logic [1:0] fifo_level_threshold_out,
	input logic fifo_threshold_met_out,
	input logic [15:0] low_threshold_out,
	input logic [15:0] high_threshold_out,
	input logic spectral_interrupt_flag_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] lvl;
	logic wa;
	assign lvl = fifo_level_threshold_out == 2'h0 ? 5'h01 : fifo_level_threshold_out == 2'h1 ?
		5'h04 : fifo_level_threshold_out == 2'h2 ? 5'h08 : 5'h10;
	assign wa = reg_wr_in;
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);
	a_low_latch:
	assert property (wa && reg_addr_in == 8'h84 |=> $stable(low_threshold_out))
		else $error("low threshold moved on low byte write");
	a_low_apply:
	assert property (wa && reg_addr_in == 8'h85 |=> low_threshold_out[15:8] == $past(reg_wdata_in))
		else $error("low threshold high byte not applied");
	a_high_apply:
	assert property (wa && reg_addr_in == 8'h87 |=> high_threshold_out[15:8] == $past(reg_wdata_in))
		else $error("high threshold high byte not applied");
	a_flk_ceiling:
	assert property (wa && reg_addr_in == 8'hCF && reg_wdata_in[7:4] <= 4'hA
		|=> flicker_gain_ceiling_out == $past(reg_wdata_in[7:4])) else $error("flicker ceiling");
	a_spc_ceiling:
	assert property (wa && reg_addr_in == 8'hCF && reg_wdata_in[3:0] <= 4'hA
		|=> spectral_gain_ceiling_out == $past(reg_wdata_in[3:0])) else $error("spectral ceiling");
	a_cfg_write:
	assert property (wa && reg_addr_in == 8'hB1 |=> {fifo_level_threshold_out,
		flicker_auto_gain_enable_out, spectral_auto_gain_enable_out} == $past({reg_wdata_in[7:6],
		reg_wdata_in[3:2]})) else $error("fifo and gain config write");
	a_part_read:
	assert property (reg_rd_in && reg_addr_in == 8'h92 |=> reg_rdata_out == {PART_CODE, 2'h0})
		else $error("part code read");
	a_flag_sticky:
	assert property (spectral_interrupt_flag_out && !(wa && reg_addr_in == 8'h93 &&
		reg_wdata_in[3]) |=> spectral_interrupt_flag_out) else $error("flag dropped");
	a_fifo_met:
	assert property (!$past(rst_in) |-> fifo_threshold_met_out == $past(fifo_fill_level_in >= lvl))
		else $error("fifo threshold compare");
endmodule // stac_config_props

bind stac_config_regs stac_config_props #(.PART_CODE(PART_CODE)) u_props (.*);

// ==== sim/stac_host_model.sv ====
// Host model that issues register accesses and channel zero results.
module stac_host_model (
	// Clock.
	input logic ref_clk_in,
	// Register port.
	output logic reg_wr_in,
	output logic reg_rd_in,
	output logic [7:0] reg_addr_in,
	output logic [7:0] reg_wdata_in,
	input logic [7:0] reg_rdata_out,
	// Result stream.
	output logic result_valid_in,
	output logic [15:0] channel_zero_result_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		reg_addr_in = 8'h00;
		reg_wdata_in = 8'h00;
		result_valid_in = 1'b0;
		channel_zero_result_in = 16'h0000;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= a;
		reg_wdata_in <= d;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
		reg_wdata_in <= ~d;
		#1;
	endtask
	// Both threshold bytes go out as two separate writes, low byte first. 
	task automatic thr(input logic [7:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 8'h01, v[15:8]);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= a;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		#1 d = reg_rdata_out;
	endtask
	task automatic res(input logic [15:0] v);
		@(posedge ref_clk_in);
		result_valid_in <= 1'b1;
		channel_zero_result_in <= v;
		@(posedge ref_clk_in);
		result_valid_in <= 1'b0;
		channel_zero_result_in <= ~v;
		repeat (2) @(posedge ref_clk_in);
		#1;
	endtask
endmodule // stac_host_model

// ==== sim/tb.sv ====
// Self-checking bench for the configuration register bank.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] AUX = 4'h5; // Arbitrary value.
	localparam logic [2:0] REV = 3'h3; // Arbitrary value.
	localparam logic [5:0] PART = 6'h2A; // Arbitrary value.
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic reg_wr_in, reg_rd_in, result_valid_in, fifo_threshold_met_out;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rd_val;
	logic [15:0] channel_zero_result_in, low_threshold_out, high_threshold_out;
	logic [4:0] fifo_fill_level_in = 5'h00;
	logic [4:0] lv [4] = '{5'h01, 5'h04, 5'h08, 5'h10};
	logic [3:0] flicker_gain_ceiling_out, spectral_gain_ceiling_out;
	logic [1:0] fifo_level_threshold_out;
	logic flicker_auto_gain_enable_out, spectral_auto_gain_enable_out, spectral_interrupt_flag_out;
	int errors = 0;
	int checks_done = 0;
	stac_config_regs #(.AUX_CODE(AUX), .REV_CODE(REV), .PART_CODE(PART)) dut (.*);
	stac_host_model host (.*);
	initial
		forever #5 ref_clk_in = ~ref_clk_in;
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic end_of_test();
		if (errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic t_reset();
		chk("ceilings", 16'({flicker_gain_ceiling_out, spectral_gain_ceiling_out}), 16'h0099);
		chk("fifo_level_threshold", 16'(fifo_level_threshold_out), 16'h0002);
		chk("flk_agc", 16'(flicker_auto_gain_enable_out), 16'h0001);
		chk("spc_agc", 16'(spectral_auto_gain_enable_out), 16'h0000);
		chk("low_th", low_threshold_out, 16'h0000);
		chk("high_th", high_threshold_out, 16'h0000);
	endtask
	task automatic t_ident();
		host.wr(8'h92, 8'h00);
		host.rd(8'h92, rd_val);
		chk("part_id", 16'(rd_val), 16'({PART, 2'h0}));
		host.rd(8'h90, rd_val);
		chk("aux_id", 16'(rd_val), 16'(AUX));
		host.rd(8'h91, rd_val);
		chk("revision_code", 16'(rd_val), 16'(REV));
	endtask
	task automatic t_gain();
		host.wr(8'hCF, 8'hA3);
		chk("ceilings", 16'({flicker_gain_ceiling_out, spectral_gain_ceiling_out}), 16'h00A3);
		host.wr(8'hCF, 8'hFF);
		chk("ceil_clamp", 16'({flicker_gain_ceiling_out, spectral_gain_ceiling_out}), 16'h00AA);
		host.rd(8'hCF, rd_val);
		chk("ceil_read", 16'(rd_val), 16'h00AA);
		host.wr(8'hB1, 8'h04);
		chk("agc_en", 16'({flicker_auto_gain_enable_out, spectral_auto_gain_enable_out}), 16'h0001);
		for (int c = 0; c < 4; c++)
		begin
			host.wr(8'hB1, 8'(c * 64));
			@(posedge ref_clk_in);
			fifo_fill_level_in <= lv[c] - 5'h01;
			repeat (3) @(posedge ref_clk_in);
			#1;
			chk("met_below", 16'(fifo_threshold_met_out), 16'h0000);
			@(posedge ref_clk_in);
			fifo_fill_level_in <= lv[c];
			repeat (3) @(posedge ref_clk_in);
			#1;
			chk("met_at", 16'(fifo_threshold_met_out), 16'h0001);
		end
		host.rd(8'hB1, rd_val);
		chk("cfg_read", 16'(rd_val), 16'h00C0);
	endtask
	task automatic t_thr();
		host.wr(8'h84, 8'h34);
		chk("low_latched", low_threshold_out, 16'h0000);
		host.rd(8'h84, rd_val);
		chk("latch_read", 16'(rd_val), 16'h0034);
		host.wr(8'h85, 8'h12);
		chk("low_applied", low_threshold_out, 16'h1234);
		host.thr(8'h86, 16'h0200);
		chk("high_applied", high_threshold_out, 16'h0200);
		host.thr(8'h84, 16'h0100);
		chk("low_pair", low_threshold_out, 16'h0100);
	endtask
	task automatic t_irq();
		host.wr(8'hF9, 8'h08);
		host.wr(8'hBD, 8'h02);
		host.res(16'h0050);
		host.res(16'h0150);
		host.res(16'h0050);
		chk("run_broken", 16'(spectral_interrupt_flag_out), 16'h0000);
		host.res(16'hFFFF);
		chk("run_hit", 16'(spectral_interrupt_flag_out), 16'h0001);
		host.rd(8'h93, rd_val);
		chk("status_read", 16'(rd_val), 16'h0008);
		host.wr(8'h93, 8'h00);
		chk("clear_zero", 16'(spectral_interrupt_flag_out), 16'h0001);
		host.wr(8'h93, rd_val);
		chk("clear_one", 16'(spectral_interrupt_flag_out), 16'h0000);
		host.wr(8'hF9, 8'h00);
		host.res(16'hFFFF);
		chk("masked", 16'(spectral_interrupt_flag_out), 16'h0000);
	endtask
	initial
	begin
		#20us;
		errors++;
		end_of_test();
	end
	initial
	begin
		repeat (6) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		@(posedge ref_clk_in);
		#1;
		t_reset();
		t_ident();
		t_gain();
		t_thr();
		t_irq();
		end_of_test();
	end
endmodule // tb
